// file: verilog/hasq_pkg.sv
// constants and carrier types for the harmonic acquisition sequencer
package hasq_pkg;
  // frequencies are carried in kHz
  typedef logic [31:0] hasq_freq_t;
  typedef logic [23:0] hasq_tmr_t;
  typedef logic [15:0] hasq_harm_t;

  // ****************************************
  // oscillator sweep plan
  // ****************************************
  localparam hasq_freq_t OSC_TOP_KHZ    = 32'h0005_7e40; // 360000 kHz
  localparam hasq_freq_t OSC_BOTTOM_KHZ = 32'h0004_93e0; // 300000 kHz
  localparam hasq_freq_t SWEEP_STEP_KHZ = 32'h0000_0064; // 100 kHz
  localparam hasq_freq_t OSC_OFFSET_KHZ = 32'h0000_0190; // osc_offset_step, 400 kHz

  // ****************************************
  // if limits
  // ****************************************
  localparam hasq_freq_t IF_MIN_KHZ = 32'h0000_88b8; // 35000 kHz
  localparam hasq_freq_t IF_MAX_KHZ = 32'h0001_9a28; // 105000 kHz
  localparam hasq_freq_t WIN_LO_KHZ = 32'h0000_afc8; // 45000 kHz
  localparam hasq_freq_t WIN_HI_KHZ = 32'h0001_7318; // 95000 kHz

  // ****************************************
  // timing, clock is 10 MHz
  // ****************************************
  localparam int CLK_PER_US      = 32'ha;
  localparam int DWELL_US        = 32'h14;   // 20 us detector dwell per step
  localparam int SETTLE_US       = 32'h3e8;  // settle_interval, 1000 us
  localparam int GATE_FAST_US    = 32'h3e8;  // gate_interval, 1 kHz tolerance
  localparam int GATE_SLOW_US    = 32'h4e20; // gate_interval, 45 Hz tolerance
  localparam int DWELL_CYC       = DWELL_US * CLK_PER_US;
  localparam int SETTLE_CYC_DEF  = SETTLE_US * CLK_PER_US;
  localparam int GATE_FAST_CYC   = GATE_FAST_US * CLK_PER_US;
  localparam int GATE_SLOW_CYC_DEF = GATE_SLOW_US * CLK_PER_US;
  localparam logic [3:0] REMOTE_EVERY = 4'ha;
  localparam logic [1:0] CENTER_TRIES = 2'h2;

  typedef enum {ST_IDLE, ST_DWELL, ST_SETTLE1, ST_GATE1, ST_WAIT1,
                ST_SETTLE2, ST_GATE2, ST_WAIT2, ST_DIV, ST_FINAL} hasq_state_e;

  // counter answer after a gate closes
  typedef struct packed {
    logic       valid;
    hasq_freq_t value;
  } hasq_count_s;

  // synthesizer command
  typedef struct packed {
    logic       load;
    hasq_freq_t freq;
  } hasq_osc_s;
endpackage

// file: verilog/hasq_sequencer.sv
// acquisition and harmonic-number sequencer for a heterodyne counter
// How it works
// - the oscillator steps down repeatedly until a mixing product is countable
// - an in-range report stops the sweep and keeps the setting as first_osc_freq
// - an in-range indication only counts while the if lies in counter range
// - after the sweep a settle_interval passes, then one gate_interval count
// - after the first count the oscillator goes to first_osc_freq minus the offset
// - a second settle_interval follows, then a gate of equal length
// - the second count must come from the same harmonic and sideband
// - harmonic number is the rounded absolute count difference over the offset
// - result is harmonic times first_osc_freq, minus or plus first_if_count
// - gate, settle and offset keep the harmonic error below 0.3 at 10 MHz deviation
// - the user picks a 1 kHz or a 45 Hz minimum modulation rate
// - the 45 Hz choice uses the longer gate for both counts
// - a 45 to 95 MHz window flag steers the oscillator to centre the if
// - remote mode redoes harmonic determination once in ten measurements
`timescale 1ns/100ps
`default_nettype none
module hasq_sequencer #(
  parameter int SETTLE_CYC    = hasq_pkg::SETTLE_CYC_DEF,
  parameter int GATE_SLOW_CYC = hasq_pkg::GATE_SLOW_CYC_DEF
) (
  // clock, reset, enable
  input  wire logic                 clk,
  input  wire logic                 sys_rst,
  input  wire logic                 clkEn,
  // user mode
  input  wire logic                 slowFm,
  input  wire logic                 remote,
  // if detector and counter
  input  wire logic                 ifInRange,
  input  wire hasq_pkg::hasq_count_s ifAns,
  output logic                      gateOpen,
  // synthesizer
  output var hasq_pkg::hasq_osc_s   oscCmd,
  // results
  output var hasq_pkg::hasq_freq_t  result,
  output logic                      resultValid,
  output logic                      noSignal,
  output logic                      inWindow
);
  import hasq_pkg::*;

  hasq_state_e state, next_state;
  hasq_tmr_t   timer, next_timer;
  hasq_osc_s   next_oscCmd;
  hasq_freq_t  firstOsc, next_firstOsc;
  hasq_freq_t  firstIf, next_firstIf;
  hasq_freq_t  secondIf, next_secondIf;
  hasq_freq_t  rem, next_rem;
  hasq_freq_t  next_result;
  hasq_harm_t  harm, next_harm;
  logic        upper, next_upper;
  logic        haveN, next_haveN;
  logic        reuse, next_reuse;
  logic [3:0]  measCnt, next_measCnt;
  logic [1:0]  tries, next_tries;
  logic        next_gateOpen, next_resultValid, next_noSignal, next_inWindow;
  hasq_tmr_t   gateLen;
  logic        dwellEnd, atBottom, countOk, winOk;
  logic [47:0] prod;

  // ****************************************
  // derived terms
  // ****************************************
  assign gateLen  = slowFm ? hasq_tmr_t'(GATE_SLOW_CYC) : hasq_tmr_t'(GATE_FAST_CYC);
  assign dwellEnd = timer == hasq_tmr_t'(DWELL_CYC - 1);
  assign atBottom = oscCmd.freq < OSC_BOTTOM_KHZ + SWEEP_STEP_KHZ;
  assign countOk  = ifAns.value >= IF_MIN_KHZ && ifAns.value <= IF_MAX_KHZ;
  assign winOk    = ifAns.value >= WIN_LO_KHZ && ifAns.value <= WIN_HI_KHZ;
  assign prod     = harm * firstOsc;

  // sequencer next values; the offset and gate figures are sized so the
  // modulation error on the harmonic number stays below 0.3
  always_comb begin
    next_state       = state;
    next_timer       = timer + 24'h1;
    next_oscCmd      = oscCmd;
    next_oscCmd.load = 1'b0;
    next_firstOsc    = firstOsc;
    next_firstIf     = firstIf;
    next_secondIf    = secondIf;
    next_rem         = rem;
    next_harm        = harm;
    next_upper       = upper;
    next_haveN       = haveN;
    next_reuse       = reuse;
    next_measCnt     = measCnt;
    next_tries       = tries;
    next_gateOpen    = gateOpen;
    next_result      = result;
    next_resultValid = 1'b0;
    next_noSignal    = 1'b0;
    next_inWindow    = inWindow;
    case (state)
      ST_IDLE: begin
        next_timer = '0;
        next_tries = '0;
        if (remote && haveN && measCnt != REMOTE_EVERY - 4'h1) begin
          next_reuse   = 1'b1;
          next_measCnt = measCnt + 4'h1;
          next_oscCmd  = '{load: 1'b1, freq: firstOsc};
          next_state   = ST_SETTLE1;
        end else begin
          next_reuse   = 1'b0;
          next_measCnt = '0;
          next_haveN   = 1'b0;
          next_oscCmd  = '{load: 1'b1, freq: OSC_TOP_KHZ};
          next_state   = ST_DWELL;
        end
      end
      ST_DWELL: begin
        if (dwellEnd) begin
          next_timer = '0;
          if (ifInRange) begin
            next_firstOsc = oscCmd.freq;
            next_state    = ST_SETTLE1;
          end else if (atBottom) begin
            next_noSignal = 1'b1;
            next_oscCmd   = '{load: 1'b1, freq: OSC_TOP_KHZ};
          end else begin
            next_oscCmd = '{load: 1'b1, freq: oscCmd.freq - SWEEP_STEP_KHZ};
          end
        end
      end
      ST_SETTLE1: begin
        if (timer == hasq_tmr_t'(SETTLE_CYC - 1)) begin
          next_timer    = '0;
          next_gateOpen = 1'b1;
          next_state    = ST_GATE1;
        end
      end
      ST_GATE1: begin
        if (timer == gateLen - 24'h1) begin
          next_gateOpen = 1'b0;
          next_state    = ST_WAIT1;
        end
      end
      ST_WAIT1: begin
        next_timer = '0;
        if (ifAns.valid) begin
          next_firstIf  = ifAns.value;
          next_inWindow = winOk;
          if (!countOk) begin
            next_haveN = 1'b0;
            next_state = ST_IDLE;
          end else if (!winOk && !reuse && tries != CENTER_TRIES) begin
            // off centre: nudge down one step and count again
            next_tries    = tries + 2'h1;
            next_oscCmd   = '{load: 1'b1, freq: oscCmd.freq - SWEEP_STEP_KHZ};
            next_firstOsc = oscCmd.freq - SWEEP_STEP_KHZ;
            next_state    = ST_SETTLE1;
          end else if (reuse) begin
            next_state = ST_FINAL;
          end else begin
            next_oscCmd = '{load: 1'b1, freq: firstOsc - OSC_OFFSET_KHZ};
            next_state  = ST_SETTLE2;
          end
        end
      end
      ST_SETTLE2: begin
        if (!ifInRange) begin
          // losing the product means the sideband may have changed
          next_haveN = 1'b0;
          next_state = ST_IDLE;
        end else if (timer == hasq_tmr_t'(SETTLE_CYC - 1)) begin
          next_timer    = '0;
          next_gateOpen = 1'b1;
          next_state    = ST_GATE2;
        end
      end
      ST_GATE2: begin
        if (!ifInRange) begin
          next_gateOpen = 1'b0;
          next_haveN    = 1'b0;
          next_state    = ST_IDLE;
        end else if (timer == gateLen - 24'h1) begin
          next_gateOpen = 1'b0;
          next_state    = ST_WAIT2;
        end
      end
      ST_WAIT2: begin
        if (ifAns.valid) begin
          next_secondIf = ifAns.value;
          next_harm     = '0;
          // rounding: bias by half the offset before the repeated subtract
          next_rem = (ifAns.value > firstIf ? ifAns.value - firstIf
                                            : firstIf - ifAns.value)
                     + (OSC_OFFSET_KHZ >> 1);
          next_state = ST_DIV;
        end
      end
      ST_DIV: begin
        if (rem >= OSC_OFFSET_KHZ) begin
          next_rem  = rem - OSC_OFFSET_KHZ;
          next_harm = harm + 16'h1;
        end else begin
          // sideband from the stored pair; a rising second count is upper
          next_upper = secondIf > firstIf;
          next_haveN = 1'b1;
          next_state = ST_FINAL;
        end
      end
      ST_FINAL: begin
        next_result      = upper ? prod[31:0] + firstIf : prod[31:0] - firstIf;
        next_resultValid = 1'b1;
        next_state       = ST_IDLE;
      end
      default: next_state = ST_IDLE;
    endcase
  end

  // state registers, frozen while the enable is low
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state       <= ST_IDLE;
      timer       <= '0;
      oscCmd      <= '{load: 1'b0, freq: OSC_TOP_KHZ};
      firstOsc    <= OSC_TOP_KHZ;
      firstIf     <= '0;
      secondIf    <= '0;
      rem         <= '0;
      harm        <= '0;
      upper       <= 1'b0;
      haveN       <= 1'b0;
      reuse       <= 1'b0;
      measCnt     <= '0;
      tries       <= '0;
      gateOpen    <= 1'b0;
      result      <= '0;
      resultValid <= 1'b0;
      noSignal    <= 1'b0;
      inWindow    <= 1'b0;
    end else if (clkEn) begin
      state       <= next_state;
      timer       <= next_timer;
      oscCmd      <= next_oscCmd;
      firstOsc    <= next_firstOsc;
      firstIf     <= next_firstIf;
      secondIf    <= next_secondIf;
      rem         <= next_rem;
      harm        <= next_harm;
      upper       <= next_upper;
      haveN       <= next_haveN;
      reuse       <= next_reuse;
      measCnt     <= next_measCnt;
      tries       <= next_tries;
      gateOpen    <= next_gateOpen;
      result      <= next_result; // held until next
      resultValid <= next_resultValid;
      noSignal    <= next_noSignal;
      inWindow    <= next_inWindow;
    end
  end

  // ****************************************
  // assertions
  // ****************************************
  property p_sweepStep;
    @(posedge clk) disable iff (sys_rst)
    (clkEn && state == ST_DWELL && dwellEnd && !ifInRange && !atBottom)
      |=> oscCmd.load && oscCmd.freq == $past(oscCmd.freq) - SWEEP_STEP_KHZ;
  endproperty
  a_sweepStep: assert property (p_sweepStep) else $error("sweep step wrong");

  property p_holdFirst;
    @(posedge clk) disable iff (sys_rst)
    (clkEn && state == ST_DWELL && dwellEnd && ifInRange)
      |=> state == ST_SETTLE1 && firstOsc == oscCmd.freq && !oscCmd.load;
  endproperty
  a_holdFirst: assert property (p_holdFirst) else $error("sweep did not halt");

  property p_gateAfterSettle;
    @(posedge clk) disable iff (sys_rst)
    $rose(gateOpen) |-> $past(state) == ST_SETTLE1 || $past(state) == ST_SETTLE2;
  endproperty
  a_gateAfterSettle: assert property (p_gateAfterSettle) else $error("gate w/o settle");

  property p_offset;
    @(posedge clk) disable iff (sys_rst)
    (state == ST_SETTLE2 && $past(state) == ST_WAIT1)
      |-> oscCmd.freq == firstOsc - OSC_OFFSET_KHZ;
  endproperty
  a_offset: assert property (p_offset) else $error("offset not applied");

  property p_gateLen;
    @(posedge clk) disable iff (sys_rst)
    gateOpen |-> timer < gateLen;
  endproperty
  a_gateLen: assert property (p_gateLen) else $error("gate overran");

  property p_sameSide;
    @(posedge clk) disable iff (sys_rst)
    (clkEn && (state == ST_SETTLE2 || state == ST_GATE2) && !ifInRange)
      |=> state == ST_IDLE && !haveN && !gateOpen;
  endproperty
  a_sameSide: assert property (p_sameSide) else $error("lost product kept");

  property p_divDone;
    @(posedge clk) disable iff (sys_rst)
    (state == ST_FINAL && !reuse) |-> rem < OSC_OFFSET_KHZ;
  endproperty
  a_divDone: assert property (p_divDone) else $error("division unfinished");

  property p_strobe;
    @(posedge clk) disable iff (sys_rst)
    (resultValid && clkEn) |=> !resultValid && result == $past(result);
  endproperty
  a_strobe: assert property (p_strobe) else $error("valid not one cycle");

  property p_restart;
    @(posedge clk) disable iff (sys_rst)
    noSignal |-> oscCmd.load && oscCmd.freq == OSC_TOP_KHZ;
  endproperty
  a_restart: assert property (p_restart) else $error("no restart at top");

  c_upper:    cover property (@(posedge clk) resultValid && upper);
  c_lower:    cover property (@(posedge clk) resultValid && !upper);
  c_noSignal: cover property (@(posedge clk) noSignal);
  c_reuse:    cover property (@(posedge clk) resultValid && reuse);
endmodule
`default_nettype wire

// file: test/hasq_partner.sv
// behavioural synthesizer, if detector and event counter facing the sequencer
`timescale 1ns/100ps
`default_nettype none
module hasq_partner (
  // clock and reset
  input  wire logic                  clk,
  input  wire logic                  sys_rst,
  // scenario controls
  input  wire hasq_pkg::hasq_freq_t  fx,
  input  wire logic                  dropSig,
  input  wire logic [7:0]            ansDly,
  // sequencer side
  input  wire hasq_pkg::hasq_osc_s   oscCmd,
  input  wire logic                  gateOpen,
  output logic                       ifInRange,
  output var hasq_pkg::hasq_count_s  ifAns
);
  import hasq_pkg::*;
  hasq_freq_t lo;
  hasq_freq_t ifNow;
  hasq_freq_t ifHeld;
  logic       gatePrev;
  int         waitCnt;

  // nearest harmonic product; the offset is too small to move n here
  function automatic hasq_freq_t mixIf(hasq_freq_t f, hasq_freq_t l);
    longint n;
    longint p;
    n = (longint'(f) + longint'(l) / 2) / longint'(l);
    p = n * longint'(l);
    return (p > longint'(f)) ? hasq_freq_t'(p - f) : hasq_freq_t'(f - p);
  endfunction

  // detector claims only a countable if and goes quiet on a lost signal
  assign ifNow     = mixIf(fx, lo);
  assign ifInRange = !dropSig && ifNow >= IF_MIN_KHZ && ifNow <= IF_MAX_KHZ;

  // retune, hold the gated if, answer after a chosen delay
  always @(posedge clk) begin
    gatePrev <= gateOpen;
    ifAns.valid <= 1'b0;
    ifAns.value <= ~ifAns.value;  // no stale count between answers
    if (sys_rst) begin
      lo <= OSC_TOP_KHZ;
      ifHeld <= 32'h0;
      ifAns.value <= 32'h0;
      waitCnt <= -1;
    end else begin
      if (oscCmd.load) lo <= oscCmd.freq;
      if (gateOpen) ifHeld <= ifNow;
      if (gatePrev && !gateOpen) waitCnt <= int'(ansDly);
      else if (waitCnt > 0) waitCnt <= waitCnt - 1;
      else if (waitCnt == 0) begin
        ifAns.valid <= 1'b1;
        ifAns.value <= ifHeld;
        waitCnt <= -1;
      end
    end
  end
endmodule
`default_nettype wire

// file: test/testbench.sv
// self-checking bench for the harmonic acquisition sequencer
`timescale 1ns/100ps
`default_nettype none
module testbench;
  import hasq_pkg::*;
  localparam int SETTLE = 20;
  localparam int GSLOW  = 40;
  typedef struct packed {
    hasq_freq_t fx;
    logic       slow;
    logic [7:0] dly;
    logic       win;
    logic [7:0] steps;
  } hasq_row_s;

  logic        clk, sys_rst, clkEn, slowFm, remote, ifInRange, dropSig;
  logic        gateOpen, resultValid, noSignal, inWindow;
  logic [7:0]  ansDly;
  hasq_count_s ifAns;
  hasq_osc_s   oscCmd, hold;
  hasq_freq_t  result, fx, lastFreq;
  int          failCount, numChecks, sweepSteps, offsetLoads, gateRun, s0;

  // input, tolerance, answer delay, window flag, sweep steps
  hasq_row_s rows [4] = '{
    '{32'h0020_0b20, 1'b0, 8'h00, 1'b1, 8'h00},  // lower sideband at the top
    '{32'h001c_3a90, 1'b0, 8'h07, 1'b1, 8'h00},  // upper sideband
    '{32'h001f_47d0, 1'b1, 8'h03, 1'b0, 8'h0b},  // short sweep plus centring
    '{32'h0020_0b20, 1'b1, 8'h14, 1'b1, 8'h00}}; // slow answer

  hasq_sequencer #(.SETTLE_CYC(SETTLE), .GATE_SLOW_CYC(GSLOW)) u_hasq_sequencer (
    .clk(clk), .sys_rst(sys_rst), .clkEn(clkEn), .slowFm(slowFm), .remote(remote),
    .ifInRange(ifInRange), .ifAns(ifAns), .gateOpen(gateOpen), .oscCmd(oscCmd),
    .result(result), .resultValid(resultValid), .noSignal(noSignal), .inWindow(inWindow));
  hasq_partner u_hasq_partner (.clk(clk), .sys_rst(sys_rst), .fx(fx), .dropSig(dropSig),
    .ansDly(ansDly), .oscCmd(oscCmd), .gateOpen(gateOpen), .ifInRange(ifInRange),
    .ifAns(ifAns));

  // ****************************************
  // clock, watchdog, checking helpers
  // ****************************************
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // worst legal run is about 48k cycles
  initial begin
    repeat (90000) @(posedge clk);
    failCount++;
    $display("ERROR %0t watchdog expired", $time);
    summarize();
  end

  task automatic check(input logic ok, input string msg);
    numChecks++;
    if (!ok) begin
      failCount++;
      $display("ERROR %0t %s", $time, msg);
    end
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", numChecks, failCount);
    if (failCount == 0 && numChecks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic do_reset(input hasq_freq_t f, input logic slow);
    sys_rst = 1'b1;
    fx = f;
    slowFm = slow;
    repeat (6) @(negedge clk);
    check(gateOpen === 1'b0 && oscCmd === {1'b0, OSC_TOP_KHZ} && result === 32'h0, "reset");
    check(resultValid === 1'b0 && noSignal === 1'b0 && inWindow === 1'b0, "reset flags");
    sys_rst = 1'b0;
    @(negedge clk);
    check(oscCmd === {1'b1, OSC_TOP_KHZ}, "sweep start");
  endtask

  task automatic wait_result(input hasq_freq_t f);
    int n;
    n = 0;
    while (resultValid !== 1'b1 && n < 30000) begin
      @(negedge clk);
      n++;
    end
    check(resultValid === 1'b1, "no result in time");
    check(result === f, "wrong input frequency");
    @(negedge clk);
    check(resultValid === 1'b0 && result === f, "strobe or hold");
  endtask

  // watch loads and gate widths; sampled before this edge's updates land
  always @(posedge clk) begin
    if (sys_rst) begin
      lastFreq = OSC_TOP_KHZ;
      sweepSteps = 0;
      offsetLoads = 0;
      gateRun = 0;
    end else begin
      if (oscCmd.load === 1'b1) begin
        if (lastFreq - oscCmd.freq === SWEEP_STEP_KHZ) sweepSteps++;
        if (lastFreq - oscCmd.freq === OSC_OFFSET_KHZ) offsetLoads++;
        lastFreq = oscCmd.freq;
      end
      if (noSignal === 1'b1) check(1'b0, "unexpected no-signal");
      if (gateOpen === 1'b1) gateRun++;
      else if (gateRun != 0) begin
        if (!dropSig) check(gateRun === (slowFm ? GSLOW : GATE_FAST_CYC), "gate");
        gateRun = 0;
      end
    end
  end

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    {clkEn, slowFm, remote, dropSig, ansDly} = {1'b1, 1'b0, 1'b0, 1'b0, 8'h00};
    sys_rst = 1'b1;
    fx = rows[0].fx;
    failCount = 0;
    numChecks = 0;
    foreach (rows[i]) begin
      do_reset(rows[i].fx, rows[i].slow);
      ansDly = rows[i].dly;
      wait_result(rows[i].fx);
      check(offsetLoads === 1, "offset loads");
      check(sweepSteps === int'(rows[i].steps), "sweep steps");
      check(inWindow === rows[i].win, "window flag");
    end
    // a frozen enable holds the sweep where it stands
    do_reset(rows[2].fx, 1'b1);
    repeat (500) @(negedge clk);
    clkEn = 1'b0;
    hold = oscCmd;
    s0 = sweepSteps;
    repeat (450) @(negedge clk);
    check(oscCmd === hold && sweepSteps === s0, "enable freeze");
    clkEn = 1'b1;
    wait_result(rows[2].fx);
    // losing the signal in the second gate forces a fresh determination
    do_reset(rows[0].fx, 1'b1);
    for (int n = 0; n < 30000 && !(offsetLoads == 1 && gateOpen === 1'b1); n++)
      @(negedge clk);
    dropSig = 1'b1;
    repeat (5) @(negedge clk);
    check(gateOpen === 1'b0 && resultValid === 1'b0, "gate held on loss");
    dropSig = 1'b0;
    wait_result(rows[0].fx);
    check(offsetLoads === 2, "redetermination");
    // remote mode reuses the harmonic for nine results of ten
    remote = 1'b1;
    do_reset(rows[1].fx, 1'b1);
    wait_result(rows[1].fx);
    offsetLoads = 0;
    repeat (10) wait_result(rows[1].fx);
    check(offsetLoads === 1, "remote rate");
    summarize();
  end
endmodule
`default_nettype wire
